// [rtl/eeg_lpi_ctrl.sv]
// global eee low-power-idle control with indirect host byte access
`timescale 1ns/1ps
`include "eeg_map.svh"
module eeg_lpi_ctrl #(
	parameter int NUM_PORTS   = 4,
	parameter int STEP_CYCLES = `EEG_STEP_CYCLES,
	parameter int WAKE_CYCLES = `EEG_WAKE_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire eeg_pkg::eeg_host_s    host,
	output logic [7:0]                 host_rdata,
	input  wire eeg_pkg::eeg_port_in_s port_in [NUM_PORTS],
	output logic [NUM_PORTS-1:0]       lpi_req,
	output logic [NUM_PORTS-1:0]       next_page_en,
	output logic [15:0]                wake_err_count
);
	import eeg_pkg::*;

	// ***************************************************************
	// indirect access registers
	// ***************************************************************
	logic [7:0]           ctrl_reg;
	logic [7:0]           offset_reg;
	logic [7:0]           data_reg;
	logic [7:0]           rdata_reg;
	logic                 stop_en_reg;
	logic [15:0]          wait_reg;
	logic [NUM_PORTS-1:0] np_reg;
	logic [15:0]          err_cnt_reg;
	logic                 sel_ok;
	logic                 rd_mode;
	logic                 fetch;
	logic                 store;
	logic [NUM_PORTS-1:0] err_pulse;
	logic [2:0]           err_sum;

	// only the global eee page is served here
	assign sel_ok = ctrl_reg[`EEG_TBL_MSB:`EEG_TBL_LSB] == `EEG_TBL_EEE
		&& ctrl_reg[`EEG_PORT_MSB:0] == `EEG_PORT_GLOBAL;
	assign rd_mode = ctrl_reg[`EEG_RDSEL_BIT];
	// writing the offset byte in read mode fetches the target byte
	assign fetch = host.wr && host.addr == `EEG_IND_ADDR && sel_ok && rd_mode;
	// writing the data byte in write mode stores into the target byte
	assign store = host.wr && host.addr == `EEG_IND_DATA && sel_ok && !rd_mode;

	// read view of one global byte; reserved bytes give their fixed values
	function automatic logic [7:0] global_byte(input logic [7:0] off);
		logic [15:0] word;
		word = 16'h0;
		unique case ({off[7:1], 1'b0})
			`EEG_OFF_LPI_CTRL: begin
				word = `EEG_LPI_CTRL_RST;
				word[`EEG_STOP_EN_BIT] = stop_en_reg;
			end
			`EEG_OFF_WAIT:     word = wait_reg;
			`EEG_OFF_NP:       word = {`EEG_NP_FIXED, np_reg};
			`EEG_OFF_MIN_IDLE: word = `EEG_MIN_IDLE_RST;
			`EEG_OFF_WAKE_THR: word = `EEG_WAKE_THR;
			`EEG_OFF_PCS_DIAG: word = `EEG_PCS_DIAG_RST;
			default:           word = 16'h0;
		endcase
		// even offset is the high byte, odd the low byte
		return off[0] ? word[7:0] : word[15:8];
	endfunction

	// control and offset bytes written directly by the host
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_reg   <= 8'h0;
			offset_reg <= 8'h0;
		end else if (host.wr) begin
			if (host.addr == `EEG_IND_CTRL) begin
				ctrl_reg <= host.wdata;
			end
			if (host.addr == `EEG_IND_ADDR) begin
				offset_reg <= host.wdata;
			end
		end
	end

	// data byte holds the last fetched or written value
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_reg <= 8'h0;
		end else if (fetch) begin
			data_reg <= global_byte(host.wdata);
		end else if (host.wr && host.addr == `EEG_IND_DATA) begin
			data_reg <= host.wdata;
		end
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_reg <= 8'h0;
		end else if (host.rd) begin
			unique case (host.addr)
				`EEG_IND_CTRL: rdata_reg <= ctrl_reg;
				`EEG_IND_ADDR: rdata_reg <= offset_reg;
				`EEG_IND_DATA: rdata_reg <= data_reg;
				default:       rdata_reg <= 8'h0;
			endcase
		end
	end

	// ***************************************************************
	// writable global fields
	// ***************************************************************
	// read-only and reserved bytes silently drop the write
	always_ff @(posedge mclk) begin
		if (rst) begin
			stop_en_reg <= 1'b0;
			wait_reg    <= `EEG_WAIT_RST;
			np_reg      <= `EEG_NP_RST;
		end else if (store) begin
			unique case (offset_reg)
				`EEG_OFF_LPI_CTRL + 8'h1:
					stop_en_reg <= host.wdata[`EEG_STOP_EN_BIT];
				`EEG_OFF_WAIT:        wait_reg[15:8] <= host.wdata;
				`EEG_OFF_WAIT + 8'h1: wait_reg[7:0]  <= host.wdata;
				`EEG_OFF_NP + 8'h1:
					np_reg <= host.wdata[NUM_PORTS-1:0];
				default: ;
			endcase
		end
	end

	// ***************************************************************
	// time bases
	// ***************************************************************
	logic [$clog2(STEP_CYCLES)-1:0] step_div_reg;
	logic [$clog2(WAKE_CYCLES)-1:0] wake_div_reg;
	logic                           step;
	logic                           wtick;

	// one pulse per 1.3 ms wait unit, shared by all ports
	assign step  = step_div_reg == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1);
	assign wtick = wake_div_reg == ($clog2(WAKE_CYCLES))'(WAKE_CYCLES - 1);

	always_ff @(posedge mclk) begin
		if (rst || step) begin
			step_div_reg <= '0;
		end else begin
			step_div_reg <= step_div_reg + 1'b1;
		end
	end

	// wakeup is timed in its own finer unit
	always_ff @(posedge mclk) begin
		if (rst || wtick) begin
			wake_div_reg <= '0;
		end else begin
			wake_div_reg <= wake_div_reg + 1'b1;
		end
	end

	// ***************************************************************
	// copper ports
	// ***************************************************************
	// the uplink port has no instance, so it never idles low-power
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		eeg_port_timer u_timer (
			.mclk      (mclk),
			.rst       (rst),
			.step      (step),
			.wtick     (wtick),
			.wait_time (wait_reg),
			.stop_en   (stop_en_reg),
			.wake_thr  (`EEG_WAKE_THR),
			.pin       (port_in[p]),
			.lpi_req   (lpi_req[p]),
			.wake_err  (err_pulse[p])
		);
	end

	// ***************************************************************
	// wakeup error count
	// ***************************************************************
	always_comb begin
		err_sum = 3'h0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			err_sum = err_sum + 3'(err_pulse[i]);
		end
	end

	// saturates so a storm of errors cannot wrap back to a small count
	always_ff @(posedge mclk) begin
		if (rst) begin
			err_cnt_reg <= 16'h0;
		end else if (err_sum != 3'h0) begin
			if (err_cnt_reg > 16'hffff - {13'h0, err_sum}) begin
				err_cnt_reg <= 16'hffff;
			end else begin
				err_cnt_reg <= err_cnt_reg + {13'h0, err_sum};
			end
		end
	end

	assign host_rdata     = rdata_reg;
	assign next_page_en   = np_reg;
	assign wake_err_count = err_cnt_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_fetch_wait_lo;
		host.wr && host.addr == `EEG_IND_ADDR && sel_ok && rd_mode
			&& host.wdata == `EEG_OFF_WAIT + 8'h1;
	endsequence
	sequence s_read_data;
		host.rd && host.addr == `EEG_IND_DATA;
	endsequence

	// host strobes come every other cycle, so the read follows two later
	a_fetch_low_byte: assert property (s_fetch_wait_lo ##2 s_read_data
		|=> host_rdata == $past(wait_reg[7:0], 3))
		else $error("indirect read of wait low byte wrong");
	a_store_high_byte: assert property (store && offset_reg == `EEG_OFF_WAIT
		|=> wait_reg[15:8] == $past(host.wdata) && $stable(wait_reg[7:0]))
		else $error("even offset did not hit high byte");
	a_stop_bit_write: assert property (store
		&& offset_reg == `EEG_OFF_LPI_CTRL + 8'h1
		|=> stop_en_reg == $past(host.wdata[`EEG_STOP_EN_BIT]))
		else $error("stop enable not written");
	a_np_reset: assert property ($fell(rst) |-> next_page_en == `EEG_NP_RST
		&& wait_reg == `EEG_WAIT_RST)
		else $error("reset values wrong");
	a_wrong_table: assert property (host.wr && host.addr == `EEG_IND_DATA
		&& !sel_ok |=> $stable(wait_reg) && $stable(np_reg))
		else $error("write through wrong table landed");
	a_err_count: assert property (err_sum != 3'h0
		&& err_cnt_reg < 16'hfff0
		|=> err_cnt_reg == $past(err_cnt_reg) + {13'h0, $past(err_sum)})
		else $error("wakeup error count not advanced");
	// cycles since the last wait step, kept apart from the divider itself
	logic [31:0] step_gap_reg;
	always_ff @(posedge mclk) begin
		if (rst || step) begin
			step_gap_reg <= 32'h1;
		end else begin
			step_gap_reg <= step_gap_reg + 32'h1;
		end
	end

	a_step_period: assert property (step |-> step_gap_reg == 32'(STEP_CYCLES))
		else $error("wait step period wrong");
endmodule

// [rtl/eeg_map.svh]
// offsets, field positions, reset values and timing counts of the lpi block
// How it works
// - offset byte picks a register byte, data byte reads or writes it
// - each 16-bit register is even offset high byte, odd offset low byte
// - low-power-idle logic exists only for the four copper ports
// - stop bit set: input traffic withdraws pending request; clear: it does not
// - request raised once transmit queue stays empty longer than wait time
// - wait time used only with 100BASE-TX eee enabled, same for all ports
// - wait time counts in 1.3 ms steps, resets to 0x0010
// - bits 3..0 at 0x35 enable next page per copper port, reset one
// - wakeup longer than read-only threshold 0x0201 bumps the error count
`ifndef EEG_MAP_SVH
`define EEG_MAP_SVH

// ***************************************************************
// host byte registers
// ***************************************************************
`define EEG_IND_CTRL      8'h6e
`define EEG_IND_ADDR      8'h6f
`define EEG_IND_DATA      8'ha0
`define EEG_TBL_MSB       7
`define EEG_TBL_LSB       5
`define EEG_TBL_EEE       3'h1
`define EEG_RDSEL_BIT     4
`define EEG_PORT_MSB      3
`define EEG_PORT_GLOBAL   4'h0

// ***************************************************************
// global register offsets and fields
// ***************************************************************
`define EEG_OFF_LPI_CTRL  8'h30
`define EEG_OFF_WAIT      8'h32
`define EEG_OFF_NP        8'h34
`define EEG_OFF_MIN_IDLE  8'h36
`define EEG_OFF_WAKE_THR  8'h38
`define EEG_OFF_PCS_DIAG  8'h3a
`define EEG_STOP_EN_BIT   7
`define EEG_LPI_CTRL_RST  16'h4010
`define EEG_WAIT_RST      16'h0010
`define EEG_NP_RST        4'hf
`define EEG_NP_FIXED      12'h680
`define EEG_MIN_IDLE_RST  16'h0000
`define EEG_WAKE_THR      16'h0201
`define EEG_PCS_DIAG_RST  16'h0001

// ***************************************************************
// timing
// ***************************************************************
`define EEG_CLK_NS        5
`define EEG_STEP_MS       1.3
`define EEG_STEP_CYCLES   (int'($ceil(`EEG_STEP_MS * 1.0e6 / `EEG_CLK_NS)))
`define EEG_WAKE_UNIT_NS  1000
`define EEG_WAKE_CYCLES   (`EEG_WAKE_UNIT_NS / `EEG_CLK_NS)

`endif

// [rtl/eeg_pkg.sv]
// types shared by the lpi control block
package eeg_pkg;
	// one host byte access per cycle, wr and rd are one-cycle strobes
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eeg_host_s;

	// per copper port status from queue manager, mac and phy
	typedef struct packed {
		logic eee_en;
		logic empty;
		logic push;
		logic traffic;
		logic wake_start;
		logic wake_done;
	} eeg_port_in_s;
endpackage

// [rtl/eeg_port_timer.sv]
// per-port empty-queue idle timer and wakeup duration check
`timescale 1ns/1ps
`include "eeg_map.svh"
module eeg_port_timer (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 step,
	input  wire logic                 wtick,
	input  wire logic [15:0]          wait_time,
	input  wire logic                 stop_en,
	input  wire logic [15:0]          wake_thr,
	input  wire eeg_pkg::eeg_port_in_s pin,
	output logic                      lpi_req,
	output logic                      wake_err
);
	import eeg_pkg::*;

	logic [16:0] idle_cnt_reg;
	logic        lpi_req_reg;
	logic        wake_busy_reg;
	logic [16:0] wake_cnt_reg;
	logic        wake_err_reg;
	logic        clear;

	// anything that breaks the idle run restarts it
	assign clear = !pin.eee_en || !pin.empty || pin.push
		|| (stop_en && pin.traffic);

	// idle steps, held at wait+1 so the compare never wraps
	always_ff @(posedge mclk) begin
		if (rst || clear) begin
			idle_cnt_reg <= 17'h0;
		end else if (step && idle_cnt_reg <= {1'b0, wait_time}) begin
			idle_cnt_reg <= idle_cnt_reg + 17'h1;
		end
	end

	// request only after strictly more steps than configured
	always_ff @(posedge mclk) begin
		if (rst) begin
			lpi_req_reg <= 1'b0;
		end else begin
			lpi_req_reg <= !clear && (idle_cnt_reg > {1'b0, wait_time});
		end
	end

	// wakeup duration in wake units, saturating
	always_ff @(posedge mclk) begin
		if (rst) begin
			wake_busy_reg <= 1'b0;
			wake_cnt_reg  <= 17'h0;
			wake_err_reg  <= 1'b0;
		end else begin
			wake_err_reg <= 1'b0;
			if (pin.wake_start) begin
				wake_busy_reg <= 1'b1;
				wake_cnt_reg  <= 17'h0;
			end else if (wake_busy_reg && pin.wake_done) begin
				wake_busy_reg <= 1'b0;
				wake_err_reg  <= wake_cnt_reg > {1'b0, wake_thr};
			end else if (wake_busy_reg && wtick && !wake_cnt_reg[16]) begin
				wake_cnt_reg <= wake_cnt_reg + 17'h1;
			end
		end
	end

	assign lpi_req  = lpi_req_reg;
	assign wake_err = wake_err_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_req_needs_empty: assert property (!pin.empty || pin.push |=> !lpi_req)
		else $error("lpi request with data in queue");
	a_req_eee_only: assert property (!pin.eee_en |=> !lpi_req)
		else $error("lpi request with eee off");
	a_traffic_withdraw: assert property (stop_en && pin.traffic |=> !lpi_req)
		else $error("traffic did not withdraw request");
	a_traffic_kept: assert property (!stop_en && pin.traffic && pin.empty
		&& pin.eee_en && !pin.push && idle_cnt_reg > {1'b0, wait_time}
		|=> lpi_req)
		else $error("traffic withdrew request while stop disabled");
	a_req_after_wait: assert property (!clear
		&& idle_cnt_reg > {1'b0, wait_time} |=> lpi_req)
		else $error("request missing after wait time");
	a_wake_err_pulse: assert property (wake_busy_reg && pin.wake_done
		&& !pin.wake_start |=> wake_err == $past(wake_cnt_reg > {1'b0, wake_thr}))
		else $error("wakeup error flag wrong");
endmodule

// [bench/eeg_host_model.sv]
// host processor model issuing indirect byte accesses
`timescale 1ns/1ps
`include "eeg_map.svh"
module eeg_host_model (
	input  wire logic          mclk,
	input  wire logic [7:0]    host_rdata,
	output eeg_pkg::eeg_host_s host
);
	import eeg_pkg::*;

	// idle bus shows inverted leftovers so stale values never match
	initial host = '0;

	// one byte write, raised and dropped on falling edges
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		host = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge mclk);
		host = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// one byte read, answer taken one cycle after the strobe
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		host = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge mclk);
		host = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		d = host_rdata;
	endtask

	// global table write: select table, offset, then data byte
	task automatic reg_wr(input logic [7:0] off, input logic [7:0] d);
		put(`EEG_IND_CTRL, 8'h20);
		put(`EEG_IND_ADDR, off);
		put(`EEG_IND_DATA, d);
	endtask

	// global table read: the offset write fetches the byte
	task automatic reg_rd(input logic [7:0] off, output logic [7:0] d);
		put(`EEG_IND_CTRL, 8'h30);
		put(`EEG_IND_ADDR, off);
		get(`EEG_IND_DATA, d);
	endtask
endmodule

// [bench/tb.sv]
// self-checking bench for the global lpi control block
`timescale 1ns/1ps
`include "eeg_map.svh"
module tb;
	import eeg_pkg::*;
	// short step and wake units keep the run brief
	localparam int STEP = 4;
	localparam int WAKE = 2;
	localparam logic [7:0] RST_B [12] = '{8'h40, 8'h10, 8'h00, 8'h10,
		8'h68, 8'h0f, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h01};
	logic         mclk;
	logic         rst;
	eeg_host_s    host;
	logic [7:0]   host_rdata;
	eeg_port_in_s port_in [4];
	logic [3:0]   lpi_req;
	logic [3:0]   next_page_en;
	logic [15:0]  wake_err_count;
	logic [7:0]   rb;
	int           fails;
	int           cmp_count;

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
	fails++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

	// ****************************************
	// block and host
	// ****************************************
	eeg_lpi_ctrl #(.NUM_PORTS(4), .STEP_CYCLES(STEP), .WAKE_CYCLES(WAKE)) uut (
		.mclk(mclk), .rst(rst), .host(host), .host_rdata(host_rdata),
		.port_in(port_in), .lpi_req(lpi_req), .next_page_en(next_page_en),
		.wake_err_count(wake_err_count));
	eeg_host_model host_m (.mclk(mclk), .host_rdata(host_rdata),
		.host(host));

	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// bounded wait; running out ends the run
	task automatic wait_lpi(input logic [3:0] exp, input int lim);
		int n;
		n = 0;
		while (lpi_req !== exp && n < lim) begin
			@(negedge mclk);
			n++;
		end
		`CHK(lpi_req, exp)
		if (lpi_req !== exp) wrap_up();
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		`CHK(next_page_en, 4'hf)
		`CHK(lpi_req, 4'h0)
		for (int i = 0; i < 12; i++) begin
			host_m.reg_rd(8'h30 + 8'(i), rb);
			`CHK(rb, RST_B[i])
		end
		host_m.reg_rd(8'h3c, rb);
		`CHK(rb, 8'h00)
	endtask

	task automatic t_regs;
		host_m.reg_wr(8'h33, 8'h02);
		host_m.reg_wr(8'h32, 8'h00);
		host_m.reg_rd(8'h33, rb);
		`CHK(rb, 8'h02)
		// wrong table code, then a nonzero port: data byte only, no register
		for (int i = 0; i < 2; i++) begin
			host_m.put(`EEG_IND_CTRL, i == 0 ? 8'h40 : 8'h21);
			host_m.put(`EEG_IND_ADDR, 8'h33);
			host_m.put(`EEG_IND_DATA, 8'h55);
			host_m.reg_rd(8'h33, rb);
			`CHK(rb, 8'h02)
		end
		host_m.reg_wr(8'h35, 8'h05);
		`CHK(next_page_en, 4'h5)
		host_m.reg_wr(8'h38, 8'hff);
		host_m.reg_rd(8'h38, rb);
		`CHK(rb, 8'h02)
		host_m.get(8'h10, rb);
		`CHK(rb, 8'h00)
	endtask

	// wait is 2 steps: request after the third step, not before
	task automatic t_lpi;
		@(negedge mclk);
		foreach (port_in[p]) port_in[p] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		repeat (6) @(negedge mclk);
		`CHK(lpi_req, 4'h0)
		wait_lpi(4'hf, 20);
		port_in[0].eee_en = 1'b0;
		port_in[1].push = 1'b1;
		port_in[2].empty = 1'b0;
		port_in[3].traffic = 1'b1;
		@(negedge mclk);
		port_in[1].push = 1'b0;
		port_in[3].traffic = 1'b0;
		@(negedge mclk);
		`CHK(lpi_req, 4'h8)
		host_m.reg_wr(8'h31, 8'h80);
		host_m.reg_rd(8'h31, rb);
		`CHK(rb, 8'h90)
		port_in[3].traffic = 1'b1;
		@(negedge mclk);
		port_in[3].traffic = 1'b0;
		@(negedge mclk);
		`CHK(lpi_req[3], 1'b0)
	endtask

	// a 100-cycle wake stays silent, a 1100-cycle wake, about 550 units, just past the 0x0201 threshold counts
	task automatic t_wake;
		for (int k = 0; k < 2; k++) begin
			@(negedge mclk);
			port_in[0].wake_start = 1'b1;
			@(negedge mclk);
			port_in[0].wake_start = 1'b0;
			repeat (k == 0 ? 100 : 1100) @(negedge mclk);
			port_in[0].wake_done = 1'b1;
			@(negedge mclk);
			port_in[0].wake_done = 1'b0;
			repeat (3) @(negedge mclk);
			`CHK(wake_err_count, 16'(k))
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		fails = 0;
		cmp_count = 0;
		rst = 1'b1;
		foreach (port_in[p]) port_in[p] = '0;
		// count rising edges: the x-to-0 step at time zero looks like a fall
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		t_reset();
		t_regs();
		t_lpi();
		t_wake();
		wrap_up();
	end
endmodule
